/* File: shared/gptfr_pkg.sv */
// Constants for the general purpose timer and free-running counter block.
// Assumes a 16-bit SRAM-like host bus and a 50 MHz core clock.
// Function
// - Enable bit 29 runs or halts timer
// - Enable falling edge forces preload to FFFFh
// - Preload bits 15-0, read/write, resets FFFFh
// - Timer raises repeated events at preload intervals
// - Count register returns present timer value
// - 32-bit counter from zero at 25MHz
// - Free counter wraps to zero, keeps counting
// - First read latches whole free count
// - Free counter zero within 160ns of reset
// - Free counter runs in every power state
`default_nettype none
package gptfr_pkg;

	// ------------------------------------------------------------
	// Register map (byte offsets)
	// ------------------------------------------------------------
	localparam logic [7:0]  TIMER_CONFIG_OFS     = 8'h8C;
	localparam logic [7:0]  TIMER_CURRENT_OFS    = 8'h90;
	localparam logic [7:0]  FREE_RUNNING_OFS     = 8'h9C;

	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam int          TIMER_RUN_EN_BIT     = 29;
	localparam int          TIMER_RUN_EN_HI_BIT  = TIMER_RUN_EN_BIT - 16;
	localparam logic [15:0] TIMER_PRELOAD_RST    = 16'hFFFF;
	localparam logic [15:0] TIMER_PRESENT_RST    = 16'hFFFF;
	localparam logic [31:0] FREE_COUNT_RST       = 32'h0000_0000;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int          CORE_CLK_HZ          = 50_000_000;
	localparam int          FREE_REF_HZ          = 25_000_000;
	localparam int          FREE_DIV_CYCLES      = CORE_CLK_HZ / FREE_REF_HZ;
	localparam int          FREE_CLEAR_NS        = 160;
	localparam int          FREE_CLEAR_CYCLES    = (FREE_CLEAR_NS * (CORE_CLK_HZ / 1_000_000))
	                                               / 1000;
	localparam int          RST_SYNC_CYCLES      = 2;
	localparam int          TIMER_TICK_CYCLES    = 16;

endpackage : gptfr_pkg
`default_nettype wire

/* File: logic/gptfr_rst_sync.sv */
// Reset release synchroniser.
// Assumes an asynchronous active-low reset input.
`timescale 1ns/1ns
`default_nettype none
module gptfr_rst_sync (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	output var  logic o_rst_n
);
	logic stage_reg;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage_reg <= 1'b0;
			o_rst_n   <= 1'b0;
		end else begin
			stage_reg <= 1'b1;
			o_rst_n   <= stage_reg;
		end
	end
endmodule : gptfr_rst_sync
`default_nettype wire

/* File: logic/gptfr_tick.sv */
// Tick generator: one-cycle pulse every DIV cycles while running.
// Assumes a synchronous reset copy; restarts its phase when halted.
`timescale 1ns/1ns
`default_nettype none
module gptfr_tick #(
	parameter int DIV = 2
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_run,
	output var  logic o_tick
);
	localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);

	logic [W-1:0] cnt_reg;

	if (DIV < 1) begin : g_bad_div
		$error("gptfr_tick: DIV must be at least 1");
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg <= '0;
			o_tick  <= 1'b0;
		end else if (!i_run) begin
			cnt_reg <= '0;
			o_tick  <= 1'b0;
		end else if (cnt_reg == LAST) begin
			cnt_reg <= '0;
			o_tick  <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + W'(1);
			o_tick  <= 1'b0;
		end
	end
endmodule : gptfr_tick
`default_nettype wire

/* File: logic/gptfr_top.sv */
// General purpose down timer and 32-bit free-running counter.
// Assumes a 16-bit SRAM-like host bus sampled synchronously to i_core_clk.
`timescale 1ns/1ns
`default_nettype none
module gptfr_top #(
	parameter int TICK_CYCLES = gptfr_pkg::TIMER_TICK_CYCLES
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic [7:1]  i_addr,
	input  wire logic        i_cs_n,
	input  wire logic        i_rd_n,
	input  wire logic        i_wr_n,
	input  wire logic [15:0] i_data,
	output var  logic [15:0] o_data,
	output logic             o_data_oe,
	output var  logic        o_timer_event,
	output logic             o_timer_running
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (TICK_CYCLES < 1) begin : g_bad_tick
		$error("gptfr_top: TICK_CYCLES must be at least 1");
	end
	if (gptfr_pkg::RST_SYNC_CYCLES >= gptfr_pkg::FREE_CLEAR_CYCLES) begin : g_bad_clear
		$error("gptfr_top: reset path too slow for free counter clear");
	end
	// Reference rate must divide the core clock exactly, or the count drifts
	if (gptfr_pkg::FREE_DIV_CYCLES < 1) begin : g_bad_div
		$error("gptfr_top: free counter divider must be at least 1");
	end
	if ((gptfr_pkg::CORE_CLK_HZ % gptfr_pkg::FREE_REF_HZ) != 0) begin : g_bad_ref
		$error("gptfr_top: core clock not a multiple of the free counter rate");
	end
	// Enable bit is decoded from the high half only
	if ((gptfr_pkg::TIMER_RUN_EN_BIT < 16) || (gptfr_pkg::TIMER_RUN_EN_BIT > 31)) begin : g_bad_en
		$error("gptfr_top: run enable bit must sit in the high half");
	end

	// ------------------------------------------------------------
	// Reset
	// ------------------------------------------------------------
	logic rst_n;

	gptfr_rst_sync u_rst_sync (
		.i_clk   (i_core_clk),
		.i_rst_n (i_rst_n),
		.o_rst_n (rst_n)
	);

	// ------------------------------------------------------------
	// Host strobe decode
	// ------------------------------------------------------------
	logic       rd_act;
	logic       wr_act;
	logic       rd_prev_reg;
	logic       wr_prev_reg;
	logic       rd_start;
	logic       wr_start;
	logic [7:0] word_ofs;
	logic       hi_half;

	assign rd_act   = !i_cs_n && !i_rd_n;
	assign wr_act   = !i_cs_n && !i_wr_n;
	assign rd_start = rd_act && !rd_prev_reg;
	assign wr_start = wr_act && !wr_prev_reg;
	assign word_ofs = {i_addr[7:2], 2'b00};
	assign hi_half  = i_addr[1];

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_prev_reg <= 1'b0;
			wr_prev_reg <= 1'b0;
		end else begin
			rd_prev_reg <= rd_act;
			wr_prev_reg <= wr_act;
		end
	end

	// Bus driven only while the host holds a read strobe
	assign o_data_oe = rd_act;

	// ------------------------------------------------------------
	// Timer configuration
	// ------------------------------------------------------------
	logic        run_en_reg;
	logic [15:0] preload_reg;
	logic        cfg_hi_wr;
	logic        cfg_lo_wr;
	logic        run_en_next;

	assign cfg_hi_wr   = wr_start && hi_half && (word_ofs == gptfr_pkg::TIMER_CONFIG_OFS);
	assign cfg_lo_wr   = wr_start && !hi_half && (word_ofs == gptfr_pkg::TIMER_CONFIG_OFS);
	assign run_en_next = cfg_hi_wr ? i_data[gptfr_pkg::TIMER_RUN_EN_HI_BIT] : run_en_reg;

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_en_reg <= 1'b0;
		end else begin
			run_en_reg <= run_en_next;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			preload_reg <= gptfr_pkg::TIMER_PRELOAD_RST;
		end else if (run_en_reg && !run_en_next) begin
			preload_reg <= gptfr_pkg::TIMER_PRELOAD_RST;
		end else if (cfg_lo_wr) begin
			preload_reg <= i_data;
		end
	end

	assign o_timer_running = run_en_reg;

	// ------------------------------------------------------------
	// Down timer
	// ------------------------------------------------------------
	logic        timer_tick;
	logic        run_start;
	logic [15:0] present_reg;

	// Prescaler phase restarts on enable, so the first interval is full
	gptfr_tick #(
		.DIV (TICK_CYCLES)
	) u_timer_tick (
		.i_clk   (i_core_clk),
		.i_rst_n (rst_n),
		.i_run   (run_en_reg),
		.o_tick  (timer_tick)
	);

	assign run_start = run_en_next && !run_en_reg;

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			present_reg   <= gptfr_pkg::TIMER_PRESENT_RST;
			o_timer_event <= 1'b0;
		end else begin
			o_timer_event <= 1'b0;
			if (run_start) begin
				present_reg <= preload_reg;
			end else if (run_en_reg && timer_tick) begin
				if (present_reg == 16'h0000) begin
					present_reg   <= preload_reg;
					o_timer_event <= 1'b1;
				end else begin
					present_reg <= present_reg - 16'h0001;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Free-running counter
	// ------------------------------------------------------------
	logic        free_tick;
	logic [31:0] free_reg;

	// No power-state input: nothing may stop this counter
	gptfr_tick #(
		.DIV (gptfr_pkg::FREE_DIV_CYCLES)
	) u_free_tick (
		.i_clk   (i_core_clk),
		.i_rst_n (rst_n),
		.i_run   (1'b1),
		.o_tick  (free_tick)
	);

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			free_reg <= gptfr_pkg::FREE_COUNT_RST;
		end else if (free_tick) begin
			free_reg <= free_reg + 32'h0000_0001;
		end
	end

	// ------------------------------------------------------------
	// Free count snapshot
	// ------------------------------------------------------------
	logic        free_rd;
	logic        snap_valid_reg;
	logic [31:0] snap_reg;

	assign free_rd = rd_start && (word_ofs == gptfr_pkg::FREE_RUNNING_OFS);

	// Either half may come first; the pair shares one snapshot
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			snap_valid_reg <= 1'b0;
			snap_reg       <= gptfr_pkg::FREE_COUNT_RST;
		end else if (free_rd) begin
			if (!snap_valid_reg) begin
				snap_reg       <= free_reg;
				snap_valid_reg <= 1'b1;
			end else begin
				snap_valid_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [31:0] rd_word;

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (word_ofs)
			gptfr_pkg::TIMER_CONFIG_OFS: begin
				rd_word[gptfr_pkg::TIMER_RUN_EN_BIT] = run_en_reg;
				rd_word[15:0]                        = preload_reg;
			end
			gptfr_pkg::TIMER_CURRENT_OFS: begin
				rd_word[15:0] = present_reg;
			end
			gptfr_pkg::FREE_RUNNING_OFS: begin
				rd_word = snap_valid_reg ? snap_reg : free_reg;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_data <= 16'h0000;
		end else if (rd_start) begin
			o_data <= hi_half ? rd_word[31:16] : rd_word[15:0];
		end
	end

endmodule : gptfr_top
`default_nettype wire

/* File: sim/gptfr_chk.sv */
// Assertion checker on the timer block ports.
// Assumes one idle cycle between host accesses.
`timescale 1ns/1ns
`default_nettype none
module gptfr_chk #(
	parameter int TICK_CYCLES = 16
) (
	input wire logic        i_core_clk,
	input wire logic        i_rst_n,
	input wire logic [7:1]  i_addr,
	input wire logic        i_cs_n,
	input wire logic        i_rd_n,
	input wire logic        i_wr_n,
	input wire logic [15:0] i_data,
	input wire logic [15:0] o_data,
	input wire logic        o_data_oe,
	input wire logic        o_timer_event,
	input wire logic        o_timer_running
);
	logic        acc_reg;
	logic [15:0] run_reg;
	wire logic   rd_go = !i_cs_n && !i_rd_n && !acc_reg;
	wire logic   en_wr = !i_cs_n && !i_wr_n && !acc_reg && i_addr == 7'h47;
	// A held strobe is not a new access
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) acc_reg <= 1'b0;
		else acc_reg <= !i_cs_n && !(i_rd_n && i_wr_n);
	end
	// Saturates so a long run never wraps back under the tick
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) run_reg <= 16'h0000;
		else if (!o_timer_running) run_reg <= 16'h0000;
		else if (run_reg != 16'hFFFF) run_reg <= run_reg + 16'h0001;
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	AST_OE_FOLLOWS: assert property (o_data_oe == (!i_cs_n && !i_rd_n))
		else $error("read enable wrong");
	AST_RUN_WRITE: assert property (en_wr |=> o_timer_running == $past(i_data[13]))
		else $error("run state not written");
	AST_RUN_HOLD: assert property (!en_wr |=> $stable(o_timer_running))
		else $error("run state moved alone");
	AST_EVT_ONE: assert property (o_timer_event && TICK_CYCLES > 1 |=> !o_timer_event)
		else $error("event too long");
	AST_EVT_RUN: assert property (o_timer_event |-> $past(o_timer_running))
		else $error("event while halted");
	AST_EVT_TICK: assert property (o_timer_event |-> run_reg >= TICK_CYCLES)
		else $error("event before first tick");
	AST_RD_HOLD: assert property (!rd_go |=> $stable(o_data))
		else $error("read data moved");
	AST_RST_QUIET: assert property (disable iff (1'b0)
		!i_rst_n |-> !o_timer_event && !o_timer_running && o_data == 16'h0000)
		else $error("outputs active in reset");
	cover property (o_timer_event);
	cover property (rd_go && i_addr == 7'h4F);
	cover property ($fell(o_timer_running));
endmodule : gptfr_chk
bind gptfr_top gptfr_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.i_core_clk, .i_rst_n,
	.i_addr, .i_cs_n, .i_rd_n, .i_wr_n, .i_data, .o_data, .o_data_oe, .o_timer_event,
	.o_timer_running);
`default_nettype wire

/* File: sim/gptfr_host.sv */
// Host processor model on the 16-bit register bus.
// Assumes the bench owns reset and waits before the first access.
`timescale 1ns/1ns
`default_nettype none
module gptfr_host (
	input  wire logic        i_clk,
	input  wire logic [15:0] i_rdata,
	input  wire logic        i_oe,
	output logic [7:1]       o_addr,
	output logic             o_cs_n,
	output logic             o_rd_n,
	output logic             o_wr_n,
	output logic [15:0]      o_wdata
);
	time t_rd;
	initial begin
		o_addr = 7'h00;
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_wdata = 16'h0000;
	end
	// Held over the taking edge, then one idle cycle
	task automatic acc(input logic [7:1] a, input logic w, input logic [15:0] d,
		output logic [15:0] q);
		@(negedge i_clk);
		t_rd = $time;
		o_addr = a;
		o_wdata = d;
		o_cs_n = 1'b0;
		o_rd_n = w;
		o_wr_n = !w;
		@(posedge i_clk);
		@(posedge i_clk);
		q = i_oe ? i_rdata : ~i_rdata;
		@(negedge i_clk);
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_wdata = ~d;
	endtask : acc
endmodule : gptfr_host
`default_nettype wire

/* File: sim/gptfr_top_tb.sv */
// Self-checking bench for the timer and free-running counter.
// Assumes the host model drives the bus; tick shortened to 2 cycles.
`timescale 1ns/1ns
`default_nettype none
module gptfr_top_tb;
	localparam int TK = 2;
	logic        clk, rst_n, cs_n, rd_n, wr_n, oe, evt, run;
	logic [7:1]  addr;
	logic [15:0] wd, rdat, q, lo_a, lo_b;
	int          errors, num_checks;
	time         t0, t1;
	logic [22:0] rows [5] = '{{7'h46, 16'hFFFF}, {7'h47, 16'h0000}, {7'h48, 16'hFFFF},
		{7'h49, 16'h0000}, {7'h10, 16'h0000}};
	gptfr_top #(.TICK_CYCLES(TK)) dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
		.i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data(wd), .o_data(rdat),
		.o_data_oe(oe), .o_timer_event(evt), .o_timer_running(run));
	gptfr_host host_u (.i_clk(clk), .i_rdata(rdat), .i_oe(oe), .o_addr(addr),
		.o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_wdata(wd));
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
		end
	endtask : cmp
	task automatic rd(input logic [7:1] a);
		host_u.acc(a, 1'b0, 16'h0000, q);
	endtask : rd
	task automatic wr(input logic [7:1] a, input logic [15:0] d);
		host_u.acc(a, 1'b1, d, q);
	endtask : wr
	task automatic wait_evt;
		int n;
		n = 0;
		while (evt !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		cmp({15'h0, evt}, 16'h0001);
	endtask : wait_evt
	task automatic do_reset;
		rst_n = 1'b0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
	endtask : do_reset
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Whole run is a few hundred cycles
	initial begin
		#1_000_000;
		errors++;
		close_out();
	end
	initial begin
		errors = 0;
		num_checks = 0;
		rst_n = 1'b1;
		#1;
		do_reset();
		foreach (rows[i]) begin
			rd(rows[i][22:16]);
			cmp(q, rows[i][15:0]);
		end
		rd(7'h4F);
		t0 = host_u.t_rd;
		cmp(q, 16'h0000);
		repeat (100) @(negedge clk);
		rd(7'h4E);
		lo_a = q;
		rd(7'h4E);
		t1 = host_u.t_rd;
		lo_b = q;
		rd(7'h4F);
		cmp(q, 16'h0000);
		cmp(lo_b - lo_a, 16'((t1 - t0) / 40));
		wr(7'h46, 16'h0003);
		rd(7'h46);
		cmp(q, 16'h0003);
		wr(7'h47, 16'h2000);
		cmp({15'h0, run}, 16'h0001);
		rd(7'h47);
		cmp(q, 16'h2000);
		wait_evt();
		t0 = $time;
		@(negedge clk);
		wait_evt();
		cmp(16'(($time - t0) / 20), 16'(4 * TK));
		rd(7'h48);
		cmp({15'h0, q <= 16'h0003}, 16'h0001);
		wr(7'h47, 16'h0000);
		cmp({15'h0, run}, 16'h0000);
		rd(7'h46);
		cmp(q, 16'hFFFF);
		rd(7'h48);
		lo_a = q;
		wr(7'h48, 16'h1234);
		repeat (20) @(negedge clk);
		rd(7'h48);
		cmp(q, lo_a);
		do_reset();
		rd(7'h4E);
		cmp({15'h0, q < 16'h0008}, 16'h0001);
		rd(7'h4F);
		cmp(q, 16'h0000);
		close_out();
	end
endmodule : gptfr_top_tb
`default_nettype wire
